// [core/pbg_params.svh]
// constants for the second port block: offsets, fields, reset values
`ifndef PBG_PARAMS_SVH
`define PBG_PARAMS_SVH

`define PBG_ADDR_W         4
`define PBG_OFF_PINS       4'h0
`define PBG_OFF_DIRECTION  4'h1
`define PBG_OFF_LATCH      4'h2
`define PBG_OFF_INTCTL     4'h3
`define PBG_OFF_INTCTL2    4'h4
`define PBG_OFF_IRQ_STAT   4'h5
`define PBG_OFF_IRQ_CLR    4'h6
`define PBG_OFF_IRQ_EN     4'h7

`define PBG_BIT_CHG_FLAG   0
`define PBG_BIT_PU_DIS_N   7
`define PBG_BIT_EV_CHANGE  0

`define PBG_RST_DIRECTION  8'hFF
`define PBG_RST_LATCH      8'h00
`define PBG_RST_PU_DIS_N   1'h1
`define PBG_RST_IRQ_EN     8'h00

`define PBG_CHG_LO         4
`define PBG_PWM_CH4        4
`define PBG_PWM_CH5        5
`define PBG_PIN_CH5        4
`define PBG_PIN_ALT_CH4    5

`endif

// [core/pbg_pkg.sv]
// types shared by the second port block
package pbg_pkg;
  typedef logic [7:0] pbg_byte_t;
  typedef logic [3:0] pbg_addr_t;
  typedef logic [5:0] pbg_pwm_t;
endpackage : pbg_pkg

// [core/pbg_port.sv]
// second general-purpose port with change interrupt and pwm pin sharing
//
// Function
// - eight pins: direction, latch, input each
// - direction 1 floats pin, 0 drives latch
// - latch readable; read-modify-write uses latch
// - cleared pull-up control enables all pull-ups
// - pull-up off on any output pin
// - reset leaves pull-ups disabled
// - only upper input pins detect change
// - compare against reference from last read
// - ORed upper mismatches set change flag
// - change interrupt wakes device from sleep
// - port access refreshes reference, except move-destination
// - persisting mismatch keeps setting the flag
// - pin returning ends mismatch by itself
// - pins 0-3 share pwm 0-3, pin 4 pwm 5
// - config bit moves pwm 4 onto pin 5
`timescale 1ns/1ps
`include "pbg_params.svh"

module pbg_port
  import pbg_pkg::*;
#(
  parameter int PIN_W = 8
) (
  input  wire logic      clk_in,          // 20 MHz instruction clock
  input  wire logic      rst_in,          // synchronous reset, active high
  input  wire pbg_addr_t addr_in,         // register address
  input  wire pbg_byte_t wr_data_in,      // write data
  input  wire logic      wr_en_in,        // write strobe
  input  wire logic      rd_en_in,        // read strobe
  input  wire logic      mm_move_dest_in, // write is a memory-to-memory move
  output pbg_byte_t      rd_data_out,     // read data, cycle after strobe
  input  wire pbg_byte_t pin_in,          // sensed pin levels
  output pbg_byte_t      pin_out,         // pin drive value
  output pbg_byte_t      pin_oe_n_out,    // low while pin is driven
  output pbg_byte_t      pullup_en_out,   // weak pull-up enables
  input  wire pbg_pwm_t  pwm_in,          // pwm channel outputs
  input  wire pbg_pwm_t  pwm_own_in,      // pwm channel owns its pin
  input  wire logic      pwm_ch4_alternate_pin_select_in, // pwm 4 on pin 5
  output logic           wake_out,        // wake request from sleep
  output logic           irq_out          // level interrupt
);

  // elaboration-time guard: the fixed maps below only serve eight pins
  if (PIN_W != 8) begin : g_pin_w_check
    $error("pbg_port serves exactly eight pins");
  end

  function automatic logic reg_hit(input pbg_addr_t a, input pbg_addr_t off);
    reg_hit = (a == off);
  endfunction : reg_hit

  pbg_byte_t second_port_direction;
  pbg_byte_t second_port_output_latch;
  logic      pullup_disable_n;
  logic      port_change_irq_flag;
  pbg_byte_t chg_ref;
  pbg_byte_t pin_meta;
  pbg_byte_t pin_sync;
  pbg_byte_t irq_stat;
  pbg_byte_t irq_en;
  logic      chg_mismatch;
  pbg_byte_t next_drive;
  pbg_byte_t next_oe_n;
  logic      wr_pins;
  logic      rd_pins;
  logic      irq_any;

  assign wr_pins = wr_en_in && reg_hit(addr_in, `PBG_OFF_PINS);
  assign rd_pins = rd_en_in && reg_hit(addr_in, `PBG_OFF_PINS);

  // two-stage synchroniser, only the second stage is read
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // direction register, all inputs after reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      second_port_direction <= `PBG_RST_DIRECTION;
    end else if (wr_en_in && reg_hit(addr_in, `PBG_OFF_DIRECTION)) begin
      second_port_direction <= wr_data_in;
    end
  end

  // writes to the pin register land in the latch as well
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      second_port_output_latch <= `PBG_RST_LATCH;
    end else if (wr_pins || (wr_en_in && reg_hit(addr_in, `PBG_OFF_LATCH))) begin
      second_port_output_latch <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pullup_disable_n <= `PBG_RST_PU_DIS_N;
    end else if (wr_en_in && reg_hit(addr_in, `PBG_OFF_INTCTL2)) begin
      pullup_disable_n <= wr_data_in[`PBG_BIT_PU_DIS_N];
    end
  end

  // a move that only targets the port does not touch the reference
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      chg_ref <= 8'h00;
    end else if (rd_pins || (wr_pins && !mm_move_dest_in)) begin
      chg_ref <= pin_sync;
    end
  end

  // combinational compare, so a pin that returns clears it at once
  always_comb begin
    chg_mismatch = 1'b0;
    for (int i = `PBG_CHG_LO; i < 8; i++) begin
      if (second_port_direction[i] && (pin_sync[i] != chg_ref[i])) begin
        chg_mismatch = 1'b1;
      end
    end
  end

  // set wins over a software clear while the mismatch lasts
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      port_change_irq_flag <= 1'b0;
    end else if (chg_mismatch) begin
      port_change_irq_flag <= 1'b1;
    end else if (wr_en_in && reg_hit(addr_in, `PBG_OFF_INTCTL)) begin
      port_change_irq_flag <= wr_data_in[`PBG_BIT_CHG_FLAG];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_stat <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (i == `PBG_BIT_EV_CHANGE && chg_mismatch) begin
          irq_stat[i] <= 1'b1;
        end else if (wr_en_in && reg_hit(addr_in, `PBG_OFF_IRQ_CLR) && wr_data_in[i]) begin
          irq_stat[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_en <= `PBG_RST_IRQ_EN;
    end else if (wr_en_in && reg_hit(addr_in, `PBG_OFF_IRQ_EN)) begin
      irq_en <= wr_data_in;
    end
  end

  assign irq_any = |(irq_stat & irq_en);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_out  <= 1'b0;
      wake_out <= 1'b0;
    end else begin
      irq_out  <= irq_any;
      wake_out <= port_change_irq_flag;
    end
  end

  // pin drive: pwm ownership first, then direction and latch
  always_comb begin
    next_drive = second_port_output_latch;
    next_oe_n  = second_port_direction;
    for (int i = 0; i < 4; i++) begin
      if (pwm_own_in[i]) begin
        next_drive[i] = pwm_in[i];
        next_oe_n[i]  = 1'b0;
      end
    end
    if (pwm_own_in[`PBG_PWM_CH5]) begin
      next_drive[`PBG_PIN_CH5] = pwm_in[`PBG_PWM_CH5];
      next_oe_n[`PBG_PIN_CH5]  = 1'b0;
    end
    if (pwm_ch4_alternate_pin_select_in && pwm_own_in[`PBG_PWM_CH4]) begin
      next_drive[`PBG_PIN_ALT_CH4] = pwm_in[`PBG_PWM_CH4];
      next_oe_n[`PBG_PIN_ALT_CH4]  = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_out       <= 8'h00;
      pin_oe_n_out  <= 8'hFF;
      pullup_en_out <= 8'h00;
    end else begin
      pin_out       <= next_drive;
      pin_oe_n_out  <= next_oe_n;
      // a driven pin never keeps its pull-up
      pullup_en_out <= {8{~pullup_disable_n}} & next_oe_n;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
    end else if (rd_en_in) begin
      case (addr_in)
        `PBG_OFF_PINS:      rd_data_out <= pin_sync;
        `PBG_OFF_DIRECTION: rd_data_out <= second_port_direction;
        `PBG_OFF_LATCH:     rd_data_out <= second_port_output_latch;
        `PBG_OFF_INTCTL:    rd_data_out <= {7'h00, port_change_irq_flag};
        `PBG_OFF_INTCTL2:   rd_data_out <= {pullup_disable_n, 7'h00};
        `PBG_OFF_IRQ_STAT:  rd_data_out <= irq_stat;
        `PBG_OFF_IRQ_EN:    rd_data_out <= irq_en;
        default:            rd_data_out <= 8'h00;
      endcase
    end else begin
      rd_data_out <= 8'h00;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  AST_DIR_FLOAT: assert property (
    (second_port_direction == 8'hFF && pwm_own_in == 6'h00) |=> pin_oe_n_out == 8'hFF)
    else $error("input pins are being driven");

  AST_DIR_DRIVE: assert property (
    (second_port_direction == 8'h00 && pwm_own_in == 6'h00)
    |=> (pin_oe_n_out == 8'h00 && pin_out == $past(second_port_output_latch)))
    else $error("output pins do not show the latch");

  AST_LATCH_READBACK: assert property (
    (wr_en_in && addr_in == `PBG_OFF_LATCH) ##1 (rd_en_in && addr_in == `PBG_OFF_LATCH)
    |=> rd_data_out == $past(wr_data_in, 2))
    else $error("latch read does not return written value");

  AST_PULLUP_OUT_OFF: assert property (
    ##1 ((pullup_en_out & ~pin_oe_n_out) == 8'h00))
    else $error("pull-up on while pin drives");

  AST_PULLUP_ENABLE: assert property (
    (!pullup_disable_n && second_port_direction == 8'hFF && pwm_own_in == 6'h00)
    |=> pullup_en_out == 8'hFF)
    else $error("pull-ups not enabled by cleared control bit");

  AST_OUTPUT_EXCLUDED: assert property (
    (second_port_direction[7:4] == 4'h0) |-> !chg_mismatch)
    else $error("output pin took part in change compare");

  AST_REF_REFRESH: assert property (
    rd_pins |=> (chg_ref == $past(pin_sync)))
    else $error("port read did not refresh reference");

  AST_MOVE_NO_REFRESH: assert property (
    (wr_pins && mm_move_dest_in && !rd_en_in) |=> $stable(chg_ref))
    else $error("move destination refreshed reference");

  AST_FLAG_HELD: assert property (
    chg_mismatch |=> port_change_irq_flag)
    else $error("mismatch failed to set change flag");

  AST_WAKE: assert property (
    port_change_irq_flag |=> wake_out)
    else $error("change flag did not raise wake");

  AST_PWM_SHARED: assert property (
    pwm_own_in[5] |=> (pin_out[4] == $past(pwm_in[5]) && !pin_oe_n_out[4]))
    else $error("pin 4 not following pwm channel 5");

  AST_PWM_ALT: assert property (
    (pwm_ch4_alternate_pin_select_in && pwm_own_in[4])
    |=> (pin_out[5] == $past(pwm_in[4]) && !pin_oe_n_out[5]))
    else $error("pin 5 not following pwm channel 4");

  AST_IRQ_LEVEL: assert property (
    ##1 (irq_out == $past(irq_any)))
    else $error("interrupt output not matching enabled status");

  AST_RDATA_IDLE: assert property (
    !rd_en_in |=> rd_data_out == 8'h00)
    else $error("read data not zero outside read answer");

  AST_STAT_SET: assert property (
    chg_mismatch |=> irq_stat[`PBG_BIT_EV_CHANGE])
    else $error("mismatch failed to set status bit");

  AST_PWM_LOW: assert property (
    pwm_own_in[0] |=> (pin_out[0] == $past(pwm_in[0]) && !pin_oe_n_out[0]))
    else $error("pin 0 not following pwm channel 0");

  COV_CHANGE_WAKE: cover property (chg_mismatch ##1 port_change_irq_flag ##1 wake_out);
  COV_CLEAR_FLOW: cover property (
    port_change_irq_flag && rd_pins ##1 1'b1 ##1
    (wr_en_in && addr_in == `PBG_OFF_INTCTL) ##1 !port_change_irq_flag);
  COV_PWM_ALT: cover property (pwm_ch4_alternate_pin_select_in && pwm_own_in[4]);
  COV_IRQ: cover property (irq_out);

endmodule : pbg_port

// [tb/pbg_keypad.sv]
// pin-side model: keypad switches to ground, weak pull-ups, floating pins otherwise
`timescale 1ns/1ps
module pbg_keypad
  import pbg_pkg::*;
(
  input  wire logic      clk_in,    // sample clock
  input  wire pbg_byte_t drive_in,  // device drive value
  input  wire pbg_byte_t oe_n_in,   // low where the device drives
  input  wire pbg_byte_t pullup_in, // weak pull-up enables
  input  wire pbg_byte_t key_in,    // a pressed key shorts its pin low
  output pbg_byte_t      level_out  // resulting pin levels
);
  pbg_byte_t last = 8'h00;

  always_ff @(posedge clk_in) begin
    last <= level_out;
  end

  // a floating pin shows the inverse of its last level, so a stale value never passes
  for (genvar i = 0; i < 8; i++) begin : g_pin
    assign level_out[i] = !oe_n_in[i] ? drive_in[i] : key_in[i] ? 1'b0 :
                          pullup_in[i] ? 1'b1 : ~last[i];
  end
endmodule : pbg_keypad

// [tb/pbg_port_tb_top.sv]
// self-checking bench for the second port block
`timescale 1ns/1ps
`include "pbg_params.svh"
module pbg_port_tb_top;
  import pbg_pkg::*;
  logic      clk_in = 1'b0;
  logic      rst_in = 1'b1;
  pbg_addr_t addr   = 4'h0;
  pbg_byte_t wdat   = 8'h00;
  logic      wr     = 1'b0;
  logic      rd     = 1'b0;
  logic      mm     = 1'b0;
  pbg_byte_t rdat, pins, pout, oe_n, pu, key = 8'h00;
  pbg_pwm_t  pwm    = 6'h00;
  pbg_pwm_t  own    = 6'h00;
  logic      alt    = 1'b0;
  logic      wake, irq;
  int        mismatches = 0;
  int        checked = 0;

  pbg_port uut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wr_data_in(wdat),
    .wr_en_in(wr), .rd_en_in(rd), .mm_move_dest_in(mm), .rd_data_out(rdat),
    .pin_in(pins), .pin_out(pout), .pin_oe_n_out(oe_n), .pullup_en_out(pu),
    .pwm_in(pwm), .pwm_own_in(own), .pwm_ch4_alternate_pin_select_in(alt),
    .wake_out(wake), .irq_out(irq));
  pbg_keypad pad (.clk_in(clk_in), .drive_in(pout), .oe_n_in(oe_n), .pullup_in(pu),
    .key_in(key), .level_out(pins));

  initial begin
    forever #25 clk_in = ~clk_in;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input pbg_byte_t got, input pbg_byte_t exp, input pbg_byte_t m);
    checked++;
    if ((got & m) !== (exp & m)) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h mask %h", $time, got, exp, m);
    end
  endtask : chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wait_cyc

  task automatic bus_wr(input pbg_addr_t a, input pbg_byte_t d, input logic move = 1'b0);
    @(posedge clk_in);
    addr <= a;
    wdat <= d;
    mm   <= move;
    wr   <= 1'b1;
    @(posedge clk_in);
    wr   <= 1'b0;
    mm   <= 1'b0;
  endtask : bus_wr

  // read data stand only in the cycle after the strobe, so sample there
  task automatic bus_rd(input pbg_addr_t a, input pbg_byte_t exp, input pbg_byte_t m);
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd   <= 1'b0;
    @(negedge clk_in);
    chk(rdat, exp, m);
  endtask : bus_rd

  task automatic clear_flags();
    bus_wr(`PBG_OFF_INTCTL, 8'h00);
    bus_wr(`PBG_OFF_IRQ_CLR, 8'h01);
  endtask : clear_flags

  task automatic t_reset_values();
    @(negedge clk_in);
    chk(oe_n, 8'hFF, 8'hFF);
    chk(pu, 8'h00, 8'hFF);
    bus_rd(`PBG_OFF_DIRECTION, `PBG_RST_DIRECTION, 8'hFF);
    bus_rd(`PBG_OFF_INTCTL2, 8'h80, 8'h80);
    bus_rd(4'h9, 8'h00, 8'hFF);
  endtask : t_reset_values

  task automatic t_drive_and_pullups();
    bus_wr(`PBG_OFF_LATCH, 8'hA5);
    bus_wr(`PBG_OFF_DIRECTION, 8'h0F);
    wait_cyc(4);
    @(negedge clk_in);
    chk(oe_n, 8'h0F, 8'hFF);
    bus_rd(`PBG_OFF_PINS, 8'hA0, 8'hF0);
    bus_rd(`PBG_OFF_LATCH, 8'hA5, 8'hFF);
    @(posedge clk_in);
    addr <= `PBG_OFF_LATCH;
    wdat <= 8'h5A;
    wr   <= 1'b1;
    @(posedge clk_in);
    wr   <= 1'b0;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd   <= 1'b0;
    @(negedge clk_in);
    chk(rdat, 8'h5A, 8'hFF);
    bus_wr(`PBG_OFF_INTCTL2, 8'h00);
    wait_cyc(2);
    @(negedge clk_in);
    chk(pu, 8'h0F, 8'hFF);
  endtask : t_drive_and_pullups

  task automatic t_change_irq();
    bus_wr(`PBG_OFF_DIRECTION, 8'hFF);
    wait_cyc(4);
    bus_rd(`PBG_OFF_PINS, 8'hFF, 8'hFF);
    wait_cyc(2);
    clear_flags();
    bus_wr(`PBG_OFF_IRQ_EN, 8'h01);
    wait_cyc(2);
    @(negedge clk_in);
    chk({7'h00, irq}, 8'h00, 8'h01);
    key <= 8'h40;
    wait_cyc(6);
    @(negedge clk_in);
    chk({6'h00, wake, irq}, 8'h03, 8'h03);
    bus_wr(`PBG_OFF_INTCTL, 8'h00);
    bus_rd(`PBG_OFF_INTCTL, 8'h01, 8'h01);
    bus_rd(`PBG_OFF_IRQ_STAT, 8'h01, 8'h01);
    bus_wr(`PBG_OFF_IRQ_EN, 8'h00);
    wait_cyc(2);
    @(negedge clk_in);
    chk({7'h00, irq}, 8'h00, 8'h01);
    key <= 8'h00;
    wait_cyc(6);
    clear_flags();
    bus_rd(`PBG_OFF_INTCTL, 8'h00, 8'h01);
    key <= 8'h20;
    wait_cyc(6);
    bus_rd(`PBG_OFF_PINS, 8'hDF, 8'hFF);
    wait_cyc(1);
    bus_wr(`PBG_OFF_INTCTL, 8'h00);
    bus_rd(`PBG_OFF_INTCTL, 8'h00, 8'h01);
  endtask : t_change_irq

  task automatic t_exclusion_and_move();
    bus_wr(`PBG_OFF_LATCH, 8'h00);
    bus_wr(`PBG_OFF_DIRECTION, 8'h7F);
    key <= 8'h21;
    wait_cyc(6);
    bus_wr(`PBG_OFF_INTCTL, 8'h00);
    bus_rd(`PBG_OFF_INTCTL, 8'h00, 8'h01);
    bus_wr(`PBG_OFF_DIRECTION, 8'hFF);
    key <= 8'h00;
    wait_cyc(6);
    bus_wr(`PBG_OFF_PINS, 8'hFF, 1'b1);
    wait_cyc(2);
    bus_wr(`PBG_OFF_INTCTL, 8'h00);
    bus_rd(`PBG_OFF_INTCTL, 8'h01, 8'h01);
    bus_wr(`PBG_OFF_PINS, 8'hFF);
    wait_cyc(2);
    bus_wr(`PBG_OFF_INTCTL, 8'h00);
    bus_rd(`PBG_OFF_INTCTL, 8'h00, 8'h01);
  endtask : t_exclusion_and_move

  task automatic t_pwm_share();
    @(posedge clk_in);
    own <= 6'h3F;
    pwm <= 6'h2A;
    alt <= 1'b1;
    wait_cyc(3);
    @(negedge clk_in);
    chk(oe_n, 8'hC0, 8'hFF);
    chk(pout, 8'h1A, 8'h3F);
    chk(pu, 8'hC0, 8'hFF);
    @(posedge clk_in);
    alt <= 1'b0;
    wait_cyc(3);
    @(negedge clk_in);
    chk(oe_n, 8'hE0, 8'hFF);
    chk(pout, 8'h1A, 8'h1F);
  endtask : t_pwm_share

  initial begin
    wait_cyc(6);
    rst_in <= 1'b0;
    t_reset_values();
    t_drive_and_pullups();
    t_change_irq();
    t_exclusion_and_move();
    t_pwm_share();
    test_done();
  end

  // the sequence needs well under 400 cycles; this cuts a hang short
  initial begin
    #100000;
    mismatches++;
    test_done();
  end
endmodule : pbg_port_tb_top
